// ===== rtl/dcso_regs.svh
`ifndef DCSO_REGS_SVH
`define DCSO_REGS_SVH

// ----------------------------------------------------------------------
// Object dictionary indices
// ----------------------------------------------------------------------
`define DCSO_IDX_FE_REACTION 16'h3700
`define DCSO_IDX_HW_INFO 16'h4012
`define DCSO_IDX_HW_CONFIG 16'h4013
`define DCSO_IDX_OP_COND 16'h4014

// ----------------------------------------------------------------------
// Subindices and entry counts
// ----------------------------------------------------------------------
`define DCSO_SUB_COUNT 8'h00
`define DCSO_SUB_FIRST 8'h01
`define DCSO_SUB_POWER_RAIL 8'h01
`define DCSO_SUB_LOGIC_RAIL 8'h02
`define DCSO_SUB_BOARD_TEMP 8'h03
`define DCSO_HW_INFO_COUNT 32'h0000_0001
`define DCSO_HW_CONFIG_COUNT 32'h0000_0001
`define DCSO_OP_COND_COUNT 32'h0000_0003

// ----------------------------------------------------------------------
// Reset values, reserved bits and reaction codes
// ----------------------------------------------------------------------
`define DCSO_FE_REACTION_RESET 16'hFFFF
`define DCSO_HW_CONFIG_RESET 32'h0000_0000
`define DCSO_HW_CONFIG_RSVD_BIT 0
`define DCSO_FE_CODE_NONE 16'hFFFF
`define DCSO_FE_CODE_STOP 16'h0000
`define DCSO_FE_CODE_SLOW 16'h0001
`define DCSO_FE_CODE_QUICK 16'h0002

// ----------------------------------------------------------------------
// Timing: request taken to answer, in clock-enabled cycles
// ----------------------------------------------------------------------
`define DCSO_ANSWER_LATENCY 2

`endif

// ===== rtl/dcso_pkg.sv
package dcso_pkg;

  // Action selected by the following-error reaction code
  typedef enum logic [2:0] {
    DCSO_FE_NONE = 3'b000,
    DCSO_FE_STOP = 3'b001,
    DCSO_FE_SLOW = 3'b010,
    DCSO_FE_QUICK = 3'b011,
    DCSO_FE_RSVD = 3'b100
  } dcso_fe_action_t;

  // Entry addressed by an index and subindex pair
  typedef enum logic [2:0] {
    DCSO_T_NONE = 3'b000,
    DCSO_T_FE = 3'b001,
    DCSO_T_HWI_CNT = 3'b010,
    DCSO_T_HWI_EE = 3'b011,
    DCSO_T_HWC_CNT = 3'b100,
    DCSO_T_HWC_WORD = 3'b101,
    DCSO_T_OPC_CNT = 3'b110,
    DCSO_T_OPC_VAL = 3'b111
  } dcso_target_t;

endpackage : dcso_pkg

// ===== rtl/dcso_mem.sv
`timescale 1ns/10ps

// Small reading store with a registered read port
module dcso_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [WIDTH-1:0] rdata // Registered read data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("dcso_mem: DEPTH does not fit the address width");
  end

  // Storage cleared at reset so readings start at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read returns the old word on a same-cycle write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule : dcso_mem

// ===== rtl/dcso_bank.sv
`timescale 1ns/10ps
`include "dcso_regs.svh"

// How it works
// - Reaction -1 none, 0 stop, 1 slow ramp, 2 quick ramp; rest reserved.
// - Reaction code is signed 16-bit read/write, reset to all ones.
// - Hardware information is read-only; its entry count reads one.
// - Hardware information entry one gives EEPROM bytes, zero when absent.
// - Config count is one; word one writable, resets zero, bit 0 reserved.
// - Conditions read-only, count three, readings feed transmit data.
// - Entry one is power rail millivolts, entry two logic rail millivolts.
// - Entry three is board temperature in tenths of a degree.
module dcso_bank #(
  parameter int DATA_W = 32
) (
  input wire logic CLOCK, // System clock, 125 MHz
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic CE, // Clock enable, freezes all state when low
  input wire logic REQ_VALID, // Access request strobe
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic [15:0] REQ_INDEX, // Object index
  input wire logic [7:0] REQ_SUBINDEX, // Object subindex
  input wire logic [DATA_W-1:0] REQ_WDATA, // Write data
  input wire logic [DATA_W-1:0] EEPROM_BYTES, // Attached EEPROM size
  input wire logic MEAS_VALID, // New reading strobe
  input wire logic [1:0] MEAS_SEL, // Reading subindex, 1 to 3
  input wire logic [DATA_W-1:0] MEAS_DATA, // Reading value
  output logic RSP_VALID, // Answer strobe
  output logic RSP_REFUSED, // Access refused
  output logic [DATA_W-1:0] RSP_RDATA, // Read data
  output logic [15:0] FE_REACTION, // Stored reaction code
  output dcso_pkg::dcso_fe_action_t FE_ACTION, // Decoded reaction
  output logic [DATA_W-1:0] HW_CONFIG, // Configuration word
  output logic [DATA_W-1:0] PDO_SUPPLY_RAIL_POWER_MV, // Power rail, mV
  output logic [DATA_W-1:0] PDO_SUPPLY_RAIL_LOGIC_MV, // Logic rail, mV
  output logic [DATA_W-1:0] PDO_BOARD_TEMP_DC // Board temperature, 0.1 C
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("dcso_bank: entries are 32 bits wide");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic dcso_pkg::dcso_fe_action_t fe_decode(
    input logic [15:0] code
  );
    dcso_pkg::dcso_fe_action_t act;
    case (code)
      `DCSO_FE_CODE_NONE: act = dcso_pkg::DCSO_FE_NONE;
      `DCSO_FE_CODE_STOP: act = dcso_pkg::DCSO_FE_STOP;
      `DCSO_FE_CODE_SLOW: act = dcso_pkg::DCSO_FE_SLOW;
      `DCSO_FE_CODE_QUICK: act = dcso_pkg::DCSO_FE_QUICK;
      default: act = dcso_pkg::DCSO_FE_RSVD;
    endcase
    return act;
  endfunction : fe_decode

  function automatic dcso_pkg::dcso_target_t target_of(
    input logic [15:0] idx,
    input logic [7:0] sub
  );
    dcso_pkg::dcso_target_t t;
    t = dcso_pkg::DCSO_T_NONE;
    case (idx)
      `DCSO_IDX_FE_REACTION: begin
        if (sub == `DCSO_SUB_COUNT) t = dcso_pkg::DCSO_T_FE;
      end
      `DCSO_IDX_HW_INFO: begin
        if (sub == `DCSO_SUB_COUNT) t = dcso_pkg::DCSO_T_HWI_CNT;
        else if (sub == `DCSO_SUB_FIRST) t = dcso_pkg::DCSO_T_HWI_EE;
      end
      `DCSO_IDX_HW_CONFIG: begin
        if (sub == `DCSO_SUB_COUNT) t = dcso_pkg::DCSO_T_HWC_CNT;
        else if (sub == `DCSO_SUB_FIRST) t = dcso_pkg::DCSO_T_HWC_WORD;
      end
      `DCSO_IDX_OP_COND: begin
        if (sub == `DCSO_SUB_COUNT) t = dcso_pkg::DCSO_T_OPC_CNT;
        else if (sub >= `DCSO_SUB_POWER_RAIL &&
                 sub <= `DCSO_SUB_BOARD_TEMP) t = dcso_pkg::DCSO_T_OPC_VAL;
      end
      default: t = dcso_pkg::DCSO_T_NONE;
    endcase
    return t;
  endfunction : target_of

  // ----------------------------------------------------------------------
  // Request stage
  // ----------------------------------------------------------------------
  logic s1_valid;
  logic s1_write;
  dcso_pkg::dcso_target_t s1_tgt;
  logic [DATA_W-1:0] s1_wdata;
  logic [DATA_W-1:0] meas_rdata;
  logic s1_ro;
  logic s1_rsvd;
  logic fe_we;
  logic hwc_we;

  // Decode once on intake so the answer stage sees a small target code
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s1_valid <= 1'b0;
      s1_write <= 1'b0;
      s1_tgt <= dcso_pkg::DCSO_T_NONE;
      s1_wdata <= '0;
    end else if (CE) begin
      s1_valid <= REQ_VALID;
      s1_write <= REQ_WRITE;
      s1_tgt <= target_of(REQ_INDEX, REQ_SUBINDEX);
      s1_wdata <= REQ_WDATA;
    end
  end

  // Only the reaction code and configuration word take writes
  assign s1_ro = (s1_tgt != dcso_pkg::DCSO_T_FE) &&
                 (s1_tgt != dcso_pkg::DCSO_T_HWC_WORD);
  assign s1_rsvd = fe_decode(s1_wdata[15:0]) == dcso_pkg::DCSO_FE_RSVD;
  assign fe_we = s1_valid && s1_write &&
                 s1_tgt == dcso_pkg::DCSO_T_FE && !s1_rsvd;
  assign hwc_we = s1_valid && s1_write &&
                  s1_tgt == dcso_pkg::DCSO_T_HWC_WORD;

  // ----------------------------------------------------------------------
  // Stored entries
  // ----------------------------------------------------------------------
  // Reaction code and its decoded action move together
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FE_REACTION <= `DCSO_FE_REACTION_RESET;
      FE_ACTION <= dcso_pkg::DCSO_FE_NONE;
    end else if (CE && fe_we) begin
      FE_REACTION <= s1_wdata[15:0];
      FE_ACTION <= fe_decode(s1_wdata[15:0]);
    end
  end

  // Reserved bit is forced low so software cannot set it by accident
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      HW_CONFIG <= `DCSO_HW_CONFIG_RESET;
    end else if (CE && hwc_we) begin
      HW_CONFIG <= s1_wdata;
      HW_CONFIG[`DCSO_HW_CONFIG_RSVD_BIT] <= 1'b0;
    end
  end

  // Readings copied to flops that feed the transmit process data
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PDO_SUPPLY_RAIL_POWER_MV <= '0;
      PDO_SUPPLY_RAIL_LOGIC_MV <= '0;
      PDO_BOARD_TEMP_DC <= '0;
    end else if (CE && MEAS_VALID) begin
      case (MEAS_SEL)
        2'h1: PDO_SUPPLY_RAIL_POWER_MV <= MEAS_DATA;
        2'h2: PDO_SUPPLY_RAIL_LOGIC_MV <= MEAS_DATA;
        2'h3: PDO_BOARD_TEMP_DC <= MEAS_DATA;
        default: ;
      endcase
    end
  end

  // Reading store addressed by subindex; slot zero is unused
  dcso_mem #(
    .WIDTH(DATA_W),
    .DEPTH(4),
    .AW(2)
  ) u_meas (
    .clk(CLOCK),
    .rst_n(RSTN),
    .ce(CE),
    .we(MEAS_VALID && MEAS_SEL != 2'h0),
    .waddr(MEAS_SEL),
    .wdata(MEAS_DATA),
    .raddr(REQ_SUBINDEX[1:0]),
    .rdata(meas_rdata)
  );

  // ----------------------------------------------------------------------
  // Answer stage
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  logic next_refused;

  // Read mux; unknown entries and illegal writes are refused
  always_comb begin
    next_rdata = '0;
    next_refused = 1'b0;
    case (s1_tgt)
      dcso_pkg::DCSO_T_FE: next_rdata = {{16{FE_REACTION[15]}}, FE_REACTION};
      dcso_pkg::DCSO_T_HWI_CNT: next_rdata = `DCSO_HW_INFO_COUNT;
      dcso_pkg::DCSO_T_HWI_EE: next_rdata = EEPROM_BYTES;
      dcso_pkg::DCSO_T_HWC_CNT: next_rdata = `DCSO_HW_CONFIG_COUNT;
      dcso_pkg::DCSO_T_HWC_WORD: next_rdata = HW_CONFIG;
      dcso_pkg::DCSO_T_OPC_CNT: next_rdata = `DCSO_OP_COND_COUNT;
      dcso_pkg::DCSO_T_OPC_VAL: next_rdata = meas_rdata;
      default: next_refused = 1'b1;
    endcase
    if (s1_write &&
        (s1_ro || (s1_tgt == dcso_pkg::DCSO_T_FE && s1_rsvd))) begin
      next_refused = 1'b1;
    end
    if (s1_write) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RSP_VALID <= 1'b0;
      RSP_REFUSED <= 1'b0;
      RSP_RDATA <= '0;
    end else if (CE) begin
      RSP_VALID <= s1_valid;
      RSP_REFUSED <= s1_valid && next_refused;
      RSP_RDATA <= s1_valid ? next_rdata : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  sequence s_stage(dcso_pkg::dcso_target_t t, logic w);
    s1_valid && CE && s1_tgt == t && s1_write == w;
  endsequence

  sequence s_taken;
    REQ_VALID && CE ##1 CE;
  endsequence

  a_answer_latency: assert property (s_taken |=> RSP_VALID)
    else $error("answer missing two cycles after request");
  // Mapping written out here so a slip in the decode function shows up
  a_action_decode: assert property (
    FE_ACTION != dcso_pkg::DCSO_FE_RSVD &&
    FE_ACTION == (FE_REACTION == 16'hFFFF ? dcso_pkg::DCSO_FE_NONE :
                  FE_REACTION == 16'h0000 ? dcso_pkg::DCSO_FE_STOP :
                  FE_REACTION == 16'h0001 ? dcso_pkg::DCSO_FE_SLOW :
                  FE_REACTION == 16'h0002 ? dcso_pkg::DCSO_FE_QUICK :
                  dcso_pkg::DCSO_FE_RSVD))
    else $error("reaction action disagrees with code");
  a_reaction_store: assert property (
    s_stage(dcso_pkg::DCSO_T_FE, 1'b1) ##0 !s1_rsvd
    |=> FE_REACTION == $past(s1_wdata[15:0]) && !RSP_REFUSED)
    else $error("reaction code write not stored");
  a_hwinfo_count: assert property (
    s_stage(dcso_pkg::DCSO_T_HWI_CNT, 1'b0)
    |=> RSP_RDATA == 32'h0000_0001 && !RSP_REFUSED)
    else $error("hardware information count not one");
  a_eeprom_size: assert property (
    s_stage(dcso_pkg::DCSO_T_HWI_EE, 1'b0)
    |=> RSP_RDATA == $past(EEPROM_BYTES))
    else $error("EEPROM size read wrong");
  a_config_store: assert property (
    s_stage(dcso_pkg::DCSO_T_HWC_WORD, 1'b1)
    |=> HW_CONFIG == {$past(s1_wdata[31:1]), 1'b0})
    else $error("configuration word write wrong");
  a_opcond_count: assert property (
    s_stage(dcso_pkg::DCSO_T_OPC_CNT, 1'b0) |=> RSP_RDATA == 32'h0000_0003)
    else $error("operating conditions count not three");
  a_power_rail: assert property (
    MEAS_VALID && CE && MEAS_SEL == 2'h1
    |=> PDO_SUPPLY_RAIL_POWER_MV == $past(MEAS_DATA))
    else $error("power rail reading not taken");
  a_board_temp: assert property (
    MEAS_VALID && CE && MEAS_SEL == 2'h3
    |=> PDO_BOARD_TEMP_DC == $past(MEAS_DATA))
    else $error("board temperature reading not taken");
  a_readonly_refuse: assert property (
    s1_valid && CE && s1_write && s1_ro
    |=> RSP_REFUSED && $stable(FE_REACTION) && $stable(HW_CONFIG))
    else $error("write to read-only entry not refused");

endmodule : dcso_bank

// ===== verif/dcso_master.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Fieldbus master model
// ----------------------------------------------------------------------
module dcso_master (
  input wire logic clock, // System clock
  input wire logic rsp_valid, // Answer strobe
  input wire logic rsp_refused, // Access refused
  input wire logic [31:0] rsp_rdata, // Read data
  output logic req_valid, // Request strobe
  output logic req_write, // 1 write, 0 read
  output logic [15:0] req_index, // Object index
  output logic [7:0] req_subindex, // Object subindex
  output logic [31:0] req_wdata // Write data
);
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_index = 16'h0000;
    req_subindex = 8'h00;
    req_wdata = 32'h0000_0000;
  end

  // One access; idle lines show the inverse so a stale value never matches
  task automatic access(input logic w, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd,
    output logic refused, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    refused = 1'b1;
    rd = 32'h0000_0000;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_index <= idx;
    req_subindex <= sub;
    req_wdata <= wd;
    @(posedge clock);
    req_valid <= 1'b0;
    req_write <= ~w;
    req_index <= ~idx;
    req_subindex <= ~sub;
    req_wdata <= ~wd;
    // Bounded wait for the answer strobe
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clock);
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        refused = rsp_refused;
        rd = rsp_rdata;
      end
    end
  endtask : access
endmodule : dcso_master

// ===== verif/drive_config_status_objects_tb.sv
`timescale 1ns/10ps
`include "dcso_regs.svh"

module drive_config_status_objects_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [31:0] eeprom_bytes = 32'h0000_0000;
  logic meas_valid = 1'b0;
  logic [1:0] meas_sel = 2'h0;
  logic [31:0] meas_data = 32'h0000_0000;
  logic req_valid, req_write, rsp_valid, rsp_refused;
  logic [15:0] req_index, fe_reaction;
  logic [7:0] req_subindex;
  logic [31:0] req_wdata, rsp_rdata, hw_config, pwr_mv, logic_mv, temp_dc;
  dcso_pkg::dcso_fe_action_t fe_action;
  logic refused, ok;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  // Free-running clock, 8 ns period
  always #4 clock = ~clock;

  dcso_bank dcso_bank_i (.CLOCK(clock), .RSTN(rstn), .CE(ce),
    .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_INDEX(req_index),
    .REQ_SUBINDEX(req_subindex), .REQ_WDATA(req_wdata),
    .EEPROM_BYTES(eeprom_bytes), .MEAS_VALID(meas_valid),
    .MEAS_SEL(meas_sel), .MEAS_DATA(meas_data), .RSP_VALID(rsp_valid),
    .RSP_REFUSED(rsp_refused), .RSP_RDATA(rsp_rdata),
    .FE_REACTION(fe_reaction), .FE_ACTION(fe_action), .HW_CONFIG(hw_config),
    .PDO_SUPPLY_RAIL_POWER_MV(pwr_mv), .PDO_SUPPLY_RAIL_LOGIC_MV(logic_mv),
    .PDO_BOARD_TEMP_DC(temp_dc));

  dcso_master dcso_master_i (.clock(clock), .rsp_valid(rsp_valid),
    .rsp_refused(rsp_refused), .rsp_rdata(rsp_rdata), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index),
    .req_subindex(req_subindex), .req_wdata(req_wdata));

  // ----------------------------------------------------------------------
  // Compare and access helpers
  // ----------------------------------------------------------------------
  task automatic chk32(input string name, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", name, e, g);
      n_mismatch++;
    end
  endtask : chk32

  task automatic chk_flag(input string name, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %b, seen %b", name, e, g);
      n_mismatch++;
    end
  endtask : chk_flag

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub,
    input logic e_ref, input logic [31:0] e_data);
    dcso_master_i.access(1'b0, idx, sub, 32'h0000_0000, refused, rd, ok);
    chk_flag("answer", 1'b1, ok);
    chk_flag("refused", e_ref, refused);
    chk32("rdata", e_data, rd);
  endtask : rd_chk

  task automatic wr_chk(input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, input logic e_ref);
    dcso_master_i.access(1'b1, idx, sub, wd, refused, rd, ok);
    chk_flag("answer", 1'b1, ok);
    chk_flag("refused", e_ref, refused);
    chk32("write rdata", 32'h0000_0000, rd);
    // The answer strobe stands for one cycle only
    @(negedge clock);
    chk_flag("rsp_valid", 1'b0, rsp_valid);
  endtask : wr_chk

  // Only a nonzero selector should land in a reading
  task automatic meas(input logic [1:0] sel, input logic [31:0] d);
    @(posedge clock);
    meas_valid <= 1'b1;
    meas_sel <= sel;
    meas_data <= d;
    @(posedge clock);
    meas_valid <= 1'b0;
    meas_data <= ~d;
  endtask : meas

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk32("fe_reaction", 32'h0000_FFFF, {16'h0000, fe_reaction});
    chk32("hw_config", 32'h0000_0000, hw_config);
    rd_chk(`DCSO_IDX_FE_REACTION, 8'h00, 1'b0, 32'hFFFF_FFFF);
    rd_chk(`DCSO_IDX_HW_CONFIG, 8'h01, 1'b0, 32'h0000_0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_codes();
    logic [15:0] code [4] = '{16'hFFFF, 16'h0001, 16'h0002, 16'h0000};
    logic [2:0] act [4] = '{3'b000, 3'b010, 3'b011, 3'b001};
    for (int i = 0; i < 4; i++) begin
      wr_chk(`DCSO_IDX_FE_REACTION, 8'h00, {16'h0000, code[i]}, 1'b0);
      chk32("fe_action", {29'h0, act[i]}, {29'h0, fe_action});
      rd_chk(`DCSO_IDX_FE_REACTION, 8'h00, 1'b0,
        {{16{code[i][15]}}, code[i]});
    end
    // Reserved codes at both ends of the range must not land
    wr_chk(`DCSO_IDX_FE_REACTION, 8'h00, 32'h0000_0003, 1'b1);
    wr_chk(`DCSO_IDX_FE_REACTION, 8'h00, 32'h0000_8000, 1'b1);
    rd_chk(`DCSO_IDX_FE_REACTION, 8'h00, 1'b0, 32'h0000_0000);
    $display("t_codes done");
  endtask : t_codes

  task automatic t_counts();
    logic [15:0] idx [3] = '{`DCSO_IDX_HW_INFO, `DCSO_IDX_HW_CONFIG,
      `DCSO_IDX_OP_COND};
    logic [31:0] cnt [3] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0003};
    for (int i = 0; i < 3; i++) begin
      rd_chk(idx[i], 8'h00, 1'b0, cnt[i]);
      wr_chk(idx[i], 8'h00, 32'h0000_0007, 1'b1);
      rd_chk(idx[i], 8'h00, 1'b0, cnt[i]);
    end
    rd_chk(16'h4015, 8'h00, 1'b1, 32'h0000_0000);
    $display("t_counts done");
  endtask : t_counts

  task automatic t_eeprom();
    rd_chk(`DCSO_IDX_HW_INFO, 8'h01, 1'b0, 32'h0000_0000);
    eeprom_bytes <= 32'h0000_8000;
    rd_chk(`DCSO_IDX_HW_INFO, 8'h01, 1'b0, 32'h0000_8000);
    wr_chk(`DCSO_IDX_HW_INFO, 8'h01, 32'h0000_0000, 1'b1);
    $display("t_eeprom done");
  endtask : t_eeprom

  task automatic t_config();
    wr_chk(`DCSO_IDX_HW_CONFIG, 8'h01, 32'hA5A5_5A5B, 1'b0);
    @(negedge clock);
    chk32("hw_config", 32'hA5A5_5A5A, hw_config);
    rd_chk(`DCSO_IDX_HW_CONFIG, 8'h01, 1'b0, 32'hA5A5_5A5A);
    $display("t_config done");
  endtask : t_config

  task automatic t_meas();
    logic [31:0] v [3] = '{32'h0000_5DC0, 32'h0000_2EE0, 32'hFFFF_FF9C};
    for (int i = 0; i < 3; i++) begin
      meas(2'(i + 1), v[i]);
      rd_chk(`DCSO_IDX_OP_COND, 8'(i + 1), 1'b0, v[i]);
    end
    meas(2'h0, 32'h1234_5678);
    @(negedge clock);
    chk32("power_rail", v[0], pwr_mv);
    chk32("logic_rail", v[1], logic_mv);
    chk32("board_temp", v[2], temp_dc);
    wr_chk(`DCSO_IDX_OP_COND, 8'h03, 32'h0000_0000, 1'b1);
    rd_chk(`DCSO_IDX_OP_COND, 8'h03, 1'b0, v[2]);
    $display("t_meas done");
  endtask : t_meas

  // A reading offered while the enable is low must not land
  task automatic t_freeze();
    @(posedge clock);
    ce <= 1'b0;
    meas_valid <= 1'b1;
    meas_sel <= 2'h1;
    meas_data <= 32'h0000_0BAD;
    repeat (2) @(posedge clock);
    meas_valid <= 1'b0;
    ce <= 1'b1;
    @(negedge clock);
    chk32("power_rail", 32'h0000_5DC0, pwr_mv);
    chk32("fe_reaction", 32'h0000_0000, {16'h0000, fe_reaction});
    rd_chk(`DCSO_IDX_OP_COND, 8'h01, 1'b0, 32'h0000_5DC0);
    $display("t_freeze done");
  endtask : t_freeze

  // Reset in mid-run brings every entry back to its reset value
  task automatic t_rereset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    chk32("fe_reaction", 32'h0000_FFFF, {16'h0000, fe_reaction});
    chk32("hw_config", 32'h0000_0000, hw_config);
    chk32("power_rail", 32'h0000_0000, pwr_mv);
    rd_chk(`DCSO_IDX_OP_COND, 8'h03, 1'b0, 32'h0000_0000);
    rd_chk(`DCSO_IDX_FE_REACTION, 8'h00, 1'b0, 32'hFFFF_FFFF);
    $display("t_rereset done");
  endtask : t_rereset

  // Closing report, reached from the main sequence or the timeout
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Runaway guard; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_codes();
    t_counts();
    t_eeprom();
    t_config();
    t_meas();
    t_freeze();
    t_rereset();
    give_verdict();
  end
endmodule : drive_config_status_objects_tb
